// File: hdl/rascd_top.sv
// Signal-detect and clip-detect qualification for one receive gain loop channel.
// Assumes one sample per valid cycle on the sample clock and a simple register port.
//
// How it works
// - Loss level is compared against the 32-bit squarer output.
// - Loss level bit 0 lines up with squared bit 8.
// - A 16-bit sample-count window qualifies loss of signal.
// - Loss declared once enough below-level samples fall within that window.
// - A 16-bit upper level qualifies clip onset.
// - A 16-bit lower level qualifies clip end.
// - Clip-assert window is a 16-bit sample count.
// - Clip-release window is a 16-bit sample count.
// - Clip raised when 8-bit count of high samples fits the assert window.
// - Clip dropped when 8-bit count of low samples fits the release window.
// - While clipped the programmed error value is added into the accumulator.
// - Channel 1 integration time low half has its own register.
// - Each integration time is 24 bits, upper byte in a separate register.
// - Loss window starts at the first below-level sample.
// - Accumulator cleared while the clear control bit is set.
`timescale 1ns/1ps
`default_nettype none
module rascd_top
   import rascd_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   input  wire logic [ADDR_W-1:0]  addr_i,
   input  wire logic [DATA_W-1:0]  wdata_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   output logic      [DATA_W-1:0]  rdata_o,
   input  wire logic               sample_valid_i,
   input  wire logic [SQ_W-1:0]    squared_i,
   input  wire logic [15:0]        sample_mag_i,
   input  wire logic [15:0]        loop_err_i,
   output logic                    loss_of_signal_o,
   output logic                    clip_o,
   output logic      [ACC_W-1:0]   acc_o,
   output logic      [INTEG_W-1:0] integ_time0_o,
   output logic      [INTEG_W-1:0] integ_time1_o,
   output logic                    irq_o
);
   // Configuration registers, interrupt status and port flops
   logic [15:0] loss_detect_level_reg,       loss_detect_level_next;
   logic [15:0] loss_window_length_reg,      loss_window_length_next;
   logic [15:0] loss_sample_count_reg,       loss_sample_count_next;
   logic [15:0] overload_upper_level_reg,    overload_upper_level_next;
   logic [15:0] overload_lower_level_reg,    overload_lower_level_next;
   logic [15:0] overload_assert_window_reg,  overload_assert_window_next;
   logic [15:0] overload_release_window_reg, overload_release_window_next;
   logic [15:0] clip_sample_counts_reg,      clip_sample_counts_next;
   logic [15:0] clip_error_value_reg,        clip_error_value_next;
   logic [15:0] ch0_integ_low_reg,           ch0_integ_low_next;
   logic [15:0] ch0_integ_high_reg,          ch0_integ_high_next;
   logic [15:0] ch1_integ_low_reg,           ch1_integ_low_next;
   logic [15:0] ch1_integ_high_reg,          ch1_integ_high_next;
   logic [15:0] ctrl_reg,                    ctrl_next;
   logic [EV_W-1:0] irq_status_reg,          irq_status_next;
   logic [EV_W-1:0] irq_mask_reg,            irq_mask_next;
   logic [DATA_W-1:0] rdata_reg,             rdata_next;
   logic              irq_reg,               irq_next;

   // Detector state
   logic loss_reg, loss_next;
   logic clip_reg, clip_next;

   // Sample classification
   logic       below_loss_level;
   logic       above_upper;
   logic       below_lower;
   logic [7:0] overload_assert_count;
   logic [7:0] overload_release_count;
   logic       loss_fire;
   logic       clip_on_fire;
   logic       clip_off_fire;
   logic [EV_W-1:0] events;
   logic [ACC_W-1:0] acc_w;

   // Level sits on squared bits from 8 upward; anything above bit 23 is loud
   always_comb begin
      below_loss_level = (squared_i[SQ_W-1:SQ_ALIGN_LSB]
                          < {8'h00, loss_detect_level_reg});
      above_upper      = sample_mag_i > overload_upper_level_reg;
      below_lower      = sample_mag_i < overload_lower_level_reg;
      overload_assert_count  = clip_sample_counts_reg[ASSERT_COUNT_LSB +: 8];
      overload_release_count = clip_sample_counts_reg[RELEASE_COUNT_LSB +: 8];
   end

   // Loss-of-signal qualifier, armed only while signal is present
   rascd_qualify u_loss_qual (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .enable_i (!loss_reg),
      .valid_i  (sample_valid_i),
      .hit_i    (below_loss_level),
      .window_i (loss_window_length_reg),
      .count_i  (loss_sample_count_reg),
      .fire_o   (loss_fire)
   );

   // Clip onset qualifier, armed only while no clip is present
   rascd_qualify u_clip_on_qual (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .enable_i (!clip_reg),
      .valid_i  (sample_valid_i),
      .hit_i    (above_upper),
      .window_i (overload_assert_window_reg),
      .count_i  ({8'h00, overload_assert_count}),
      .fire_o   (clip_on_fire)
   );

   // Clip release qualifier, armed only while a clip is present
   rascd_qualify u_clip_off_qual (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .enable_i (clip_reg),
      .valid_i  (sample_valid_i),
      .hit_i    (below_lower),
      .window_i (overload_release_window_reg),
      .count_i  ({8'h00, overload_release_count}),
      .fire_o   (clip_off_fire)
   );

   // Loop error accumulator with clip injection
   rascd_accum u_accum (
      .clk_i      (clk_i),
      .nrst_i     (nrst_i),
      .clear_i    (ctrl_reg[CTRL_CLEAR_BIT]),
      .valid_i    (sample_valid_i),
      .loop_err_i (loop_err_i),
      .clip_i     (clip_reg),
      .clip_err_i (clip_error_value_reg),
      .acc_o      (acc_w)
   );

   // Detector flags; loss ends on the first sample at or above the level
   always_comb begin
      loss_next = loss_reg;
      clip_next = clip_reg;
      if (loss_fire) begin
         loss_next = 1'b1;
      end else if (loss_reg && sample_valid_i && !below_loss_level) begin
         loss_next = 1'b0;
      end
      // Qualifiers are mutually armed, so only one can fire at a time
      if (clip_on_fire) begin
         clip_next = 1'b1;
      end else if (clip_off_fire) begin
         clip_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         loss_reg <= 1'b0;
         clip_reg <= 1'b0;
      end else begin
         loss_reg <= loss_next;
         clip_reg <= clip_next;
      end
   end

   // Register writes; read-only and unmapped addresses ignore writes
   always_comb begin
      loss_detect_level_next       = loss_detect_level_reg;
      loss_window_length_next      = loss_window_length_reg;
      loss_sample_count_next       = loss_sample_count_reg;
      overload_upper_level_next    = overload_upper_level_reg;
      overload_lower_level_next    = overload_lower_level_reg;
      overload_assert_window_next  = overload_assert_window_reg;
      overload_release_window_next = overload_release_window_reg;
      clip_sample_counts_next      = clip_sample_counts_reg;
      clip_error_value_next        = clip_error_value_reg;
      ch0_integ_low_next           = ch0_integ_low_reg;
      ch0_integ_high_next          = ch0_integ_high_reg;
      ch1_integ_low_next           = ch1_integ_low_reg;
      ch1_integ_high_next          = ch1_integ_high_reg;
      ctrl_next                    = ctrl_reg;
      irq_mask_next                = irq_mask_reg;
      if (wr_i) begin
         unique case (addr_i)
            CH0_LOSS_DETECT_LEVEL:   loss_detect_level_next       = wdata_i;
            CH0_LOSS_WINDOW_LENGTH:  loss_window_length_next      = wdata_i;
            CH0_LOSS_SAMPLE_COUNT:   loss_sample_count_next       = wdata_i;
            CH0_CLIP_UPPER_LEVEL:    overload_upper_level_next    = wdata_i;
            CH0_CLIP_LOWER_LEVEL:    overload_lower_level_next    = wdata_i;
            CH0_CLIP_ASSERT_WINDOW:  overload_assert_window_next  = wdata_i;
            CH0_CLIP_RELEASE_WINDOW: overload_release_window_next = wdata_i;
            CH0_CLIP_SAMPLE_COUNTS:  clip_sample_counts_next      = wdata_i;
            CH0_CLIP_ERROR_VALUE:    clip_error_value_next        = wdata_i;
            CH0_INTEG_LOW_ADDR:      ch0_integ_low_next           = wdata_i;
            CH0_INTEG_HIGH_ADDR:     ch0_integ_high_next          = wdata_i;
            CH1_INTEG_LOW_ADDR:      ch1_integ_low_next           = wdata_i;
            CH1_INTEG_HIGH_ADDR:     ch1_integ_high_next          = wdata_i;
            CTRL_ADDR:               ctrl_next                    = wdata_i;
            IRQ_MASK_ADDR:           irq_mask_next                = wdata_i[EV_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Sticky events: a new event outranks a same-cycle write-one-to-clear
   always_comb begin
      events = '0;
      events[EV_LOSS_BIT]     = loss_fire;
      events[EV_CLIP_ON_BIT]  = clip_on_fire;
      events[EV_CLIP_OFF_BIT] = clip_off_fire;
      irq_status_next = irq_status_reg;
      if (wr_i && addr_i == IRQ_STATUS_ADDR) begin
         irq_status_next = irq_status_reg & ~wdata_i[EV_W-1:0];
      end
      irq_status_next = irq_status_next | events;
      irq_next        = |(irq_status_next & irq_mask_next);
   end

   // Read data stand only in the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = '0;
      if (rd_i) begin
         unique case (addr_i)
            CH0_LOSS_DETECT_LEVEL:   rdata_next = loss_detect_level_reg;
            CH0_LOSS_WINDOW_LENGTH:  rdata_next = loss_window_length_reg;
            CH0_LOSS_SAMPLE_COUNT:   rdata_next = loss_sample_count_reg;
            CH0_CLIP_UPPER_LEVEL:    rdata_next = overload_upper_level_reg;
            CH0_CLIP_LOWER_LEVEL:    rdata_next = overload_lower_level_reg;
            CH0_CLIP_ASSERT_WINDOW:  rdata_next = overload_assert_window_reg;
            CH0_CLIP_RELEASE_WINDOW: rdata_next = overload_release_window_reg;
            CH0_CLIP_SAMPLE_COUNTS:  rdata_next = clip_sample_counts_reg;
            CH0_CLIP_ERROR_VALUE:    rdata_next = clip_error_value_reg;
            CH0_INTEG_LOW_ADDR:      rdata_next = ch0_integ_low_reg;
            CH0_INTEG_HIGH_ADDR:     rdata_next = ch0_integ_high_reg;
            CH1_INTEG_LOW_ADDR:      rdata_next = ch1_integ_low_reg;
            CH1_INTEG_HIGH_ADDR:     rdata_next = ch1_integ_high_reg;
            CTRL_ADDR:               rdata_next = ctrl_reg;
            STATE_ADDR: begin
               rdata_next[STATE_LOSS_BIT] = loss_reg;
               rdata_next[STATE_CLIP_BIT] = clip_reg;
            end
            IRQ_STATUS_ADDR:         rdata_next[EV_W-1:0] = irq_status_reg;
            IRQ_MASK_ADDR:           rdata_next[EV_W-1:0] = irq_mask_reg;
            ACC_LOW_ADDR:            rdata_next = acc_w[15:0];
            ACC_HIGH_ADDR:           rdata_next = acc_w[31:16];
            default:                 rdata_next = '0;
         endcase
      end
   end

   // Register file and port flops
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         loss_detect_level_reg       <= REG_RESET;
         loss_window_length_reg      <= REG_RESET;
         loss_sample_count_reg       <= REG_RESET;
         overload_upper_level_reg    <= REG_RESET;
         overload_lower_level_reg    <= REG_RESET;
         overload_assert_window_reg  <= REG_RESET;
         overload_release_window_reg <= REG_RESET;
         clip_sample_counts_reg      <= REG_RESET;
         clip_error_value_reg        <= REG_RESET;
         ch0_integ_low_reg           <= REG_RESET;
         ch0_integ_high_reg          <= REG_RESET;
         ch1_integ_low_reg           <= REG_RESET;
         ch1_integ_high_reg          <= REG_RESET;
         ctrl_reg                    <= REG_RESET;
         irq_status_reg              <= EV_RESET;
         irq_mask_reg                <= EV_RESET;
         rdata_reg                   <= REG_RESET;
         irq_reg                     <= 1'b0;
      end else begin
         loss_detect_level_reg       <= loss_detect_level_next;
         loss_window_length_reg      <= loss_window_length_next;
         loss_sample_count_reg       <= loss_sample_count_next;
         overload_upper_level_reg    <= overload_upper_level_next;
         overload_lower_level_reg    <= overload_lower_level_next;
         overload_assert_window_reg  <= overload_assert_window_next;
         overload_release_window_reg <= overload_release_window_next;
         clip_sample_counts_reg      <= clip_sample_counts_next;
         clip_error_value_reg        <= clip_error_value_next;
         ch0_integ_low_reg           <= ch0_integ_low_next;
         ch0_integ_high_reg          <= ch0_integ_high_next;
         ch1_integ_low_reg           <= ch1_integ_low_next;
         ch1_integ_high_reg          <= ch1_integ_high_next;
         ctrl_reg                    <= ctrl_next;
         irq_status_reg              <= irq_status_next;
         irq_mask_reg                <= irq_mask_next;
         rdata_reg                   <= rdata_next;
         irq_reg                     <= irq_next;
      end
   end

   // Outputs straight from flops; integration times join two registers
   assign rdata_o          = rdata_reg;
   assign irq_o            = irq_reg;
   assign loss_of_signal_o = loss_reg;
   assign clip_o           = clip_reg;
   assign acc_o            = acc_w;
   assign integ_time0_o    = {ch0_integ_high_reg[INTEG_HIGH_LSB +: 8],
                              ch0_integ_low_reg};
   assign integ_time1_o    = {ch1_integ_high_reg[INTEG_HIGH_LSB +: 8],
                              ch1_integ_low_reg};
endmodule
`default_nettype wire

// File: hdl/rascd_pkg.sv
// Package for the receive gain loop signal-detect and clip-detect block.
// Assumes a 16-bit register port with byte-wide register addresses.
package rascd_pkg;

   // Register port geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;

   // Register addresses
   localparam logic [7:0] CH0_INTEG_LOW_ADDR        = 8'h04;
   localparam logic [7:0] CH0_INTEG_HIGH_ADDR       = 8'h05;
   localparam logic [7:0] CH0_LOSS_DETECT_LEVEL     = 8'h08;
   localparam logic [7:0] CH0_LOSS_WINDOW_LENGTH    = 8'h09;
   localparam logic [7:0] CH0_LOSS_SAMPLE_COUNT     = 8'h0a;
   localparam logic [7:0] CH0_CLIP_UPPER_LEVEL      = 8'h0b;
   localparam logic [7:0] CH0_CLIP_LOWER_LEVEL      = 8'h0c;
   localparam logic [7:0] CH0_CLIP_ASSERT_WINDOW    = 8'h0d;
   localparam logic [7:0] CH0_CLIP_RELEASE_WINDOW   = 8'h0e;
   localparam logic [7:0] CH0_CLIP_SAMPLE_COUNTS    = 8'h0f;
   localparam logic [7:0] CH0_CLIP_ERROR_VALUE      = 8'h10;
   localparam logic [7:0] CH1_INTEG_LOW_ADDR        = 8'h11;
   localparam logic [7:0] CH1_INTEG_HIGH_ADDR       = 8'h12;
   localparam logic [7:0] CTRL_ADDR                 = 8'h20;
   localparam logic [7:0] STATE_ADDR                = 8'h21;
   localparam logic [7:0] IRQ_STATUS_ADDR           = 8'h22;
   localparam logic [7:0] IRQ_MASK_ADDR             = 8'h23;
   localparam logic [7:0] ACC_LOW_ADDR              = 8'h24;
   localparam logic [7:0] ACC_HIGH_ADDR             = 8'h25;

   // Field positions
   localparam int unsigned ASSERT_COUNT_LSB  = 8;   // Upper byte of clip sample counts
   localparam int unsigned RELEASE_COUNT_LSB = 0;   // Lower byte of clip sample counts
   localparam int unsigned INTEG_HIGH_LSB    = 0;   // Integration bits 23:16
   localparam int unsigned UPDATE_COUNT_LSB  = 8;   // Updates per sync, stored only
   localparam int unsigned CTRL_CLEAR_BIT    = 0;
   localparam int unsigned STATE_LOSS_BIT    = 0;
   localparam int unsigned STATE_CLIP_BIT    = 1;
   localparam int unsigned EV_LOSS_BIT       = 0;
   localparam int unsigned EV_CLIP_ON_BIT    = 1;
   localparam int unsigned EV_CLIP_OFF_BIT   = 2;
   localparam int unsigned EV_W              = 3;
   localparam int unsigned SQ_ALIGN_LSB      = 8;   // Level bit 0 sits on squared bit 8

   // Widths
   localparam int unsigned SQ_W    = 32;
   localparam int unsigned ACC_W   = 32;
   localparam int unsigned INTEG_W = 24;

   // Reset values
   localparam logic [15:0]     REG_RESET   = 16'h0000;
   localparam logic [EV_W-1:0] EV_RESET    = 3'h0;
   localparam logic [31:0]     ACC_RESET   = 32'h0000_0000;

endpackage

// File: hdl/rascd_qualify.sv
// Counts qualifying samples inside a window opened by the first one.
// Assumes hit_i is only meaningful while valid_i is high.
`timescale 1ns/1ps
`default_nettype none
module rascd_qualify
   import rascd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        enable_i,
   input  wire logic        valid_i,
   input  wire logic        hit_i,
   input  wire logic [15:0] window_i,
   input  wire logic [15:0] count_i,
   output logic             fire_o
);
   typedef enum logic {Q_IDLE, Q_OPEN} rascd_q_e;

   rascd_q_e    state_reg, state_next;
   logic [15:0] timer_reg, timer_next;
   logic [15:0] hits_reg,  hits_next;
   logic        fire_reg,  fire_next;

   // Window opens on the first hit; a zero length still spans that one sample
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      hits_next  = hits_reg;
      fire_next  = 1'b0;
      if (!enable_i) begin
         state_next = Q_IDLE;
      end else if (valid_i) begin
         unique case (state_reg)
            Q_IDLE: begin
               if (hit_i) begin
                  timer_next = 16'h0001;
                  hits_next  = 16'h0001;
                  state_next = Q_OPEN;
               end
            end
            Q_OPEN: begin
               timer_next = timer_reg + 16'h0001;
               if (hit_i) begin
                  hits_next = hits_reg + 16'h0001;
               end
            end
         endcase
         // A zero count never qualifies: that leaves the detector disarmed
         if (state_next == Q_OPEN) begin
            // Hits past the window never fire, even if the window was shortened
            if (count_i != 16'h0000 && hits_next >= count_i
                && (timer_next <= window_i || timer_next == 16'h0001)) begin
               fire_next  = 1'b1;
               state_next = Q_IDLE;
            end else if (timer_next >= window_i || count_i == 16'h0000) begin
               state_next = Q_IDLE; // Window spent without enough hits
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_reg <= Q_IDLE;
         timer_reg <= 16'h0000;
         hits_reg  <= 16'h0000;
         fire_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         hits_reg  <= hits_next;
         fire_reg  <= fire_next;
      end
   end

   assign fire_o = fire_reg;
endmodule
`default_nettype wire

// File: hdl/rascd_accum.sv
// Gain loop error accumulator with clip error injection.
// Assumes loop errors and clip error are two's complement 16-bit values.
`timescale 1ns/1ps
`default_nettype none
module rascd_accum
   import rascd_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             clear_i,
   input  wire logic             valid_i,
   input  wire logic [15:0]      loop_err_i,
   input  wire logic             clip_i,
   input  wire logic [15:0]      clip_err_i,
   output logic      [ACC_W-1:0] acc_o
);
   logic [ACC_W-1:0] acc_reg, acc_next;
   logic [ACC_W-1:0] loop_ext;
   logic [ACC_W-1:0] clip_ext;

   // Clear wins over any sample arriving in the same cycle
   always_comb begin
      loop_ext = {{(ACC_W-16){loop_err_i[15]}}, loop_err_i};
      clip_ext = {{(ACC_W-16){clip_err_i[15]}}, clip_err_i};
      acc_next = acc_reg;
      if (clear_i) begin
         acc_next = ACC_RESET;
      end else if (valid_i) begin
         if (clip_i) begin
            acc_next = acc_reg + loop_ext + clip_ext;
         end else begin
            acc_next = acc_reg + loop_ext;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         acc_reg <= ACC_RESET;
      end else begin
         acc_reg <= acc_next;
      end
   end

   assign acc_o = acc_reg;
endmodule
`default_nettype wire

// File: dv/rascd_props.sv
// Port checker for the signal-detect and clip-detect block.
// Assumes binding to rascd_top, one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rascd_props
   import rascd_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        sample_valid_i,
   input wire logic        loss_of_signal_o,
   input wire logic        clip_o,
   input wire logic [31:0] acc_o,
   input wire logic [23:0] integ_time1_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Integration halves land one edge after a lone write and are checked two edges after it
   a_integ_low: assert property (
      wr_i && addr_i == CH1_INTEG_LOW_ADDR ##1 !wr_i |=> integ_time1_o[15:0] == $past(wdata_i, 2))
      else $error("integration low half wrong");
   a_integ_high: assert property (
      wr_i && addr_i == CH1_INTEG_HIGH_ADDR ##1 !wr_i
      |=> integ_time1_o[23:16] == $past(wdata_i[7:0], 2)) else $error("integration high byte wrong");
   a_error_readback: assert property (
      wr_i && addr_i == CH0_CLIP_ERROR_VALUE ##1 rd_i && addr_i == CH0_CLIP_ERROR_VALUE
      |=> rdata_o == $past(wdata_i, 2)) else $error("clip error readback wrong");
   // Clip flag moves and loss rises two edges after a taken sample; loss falls one edge after
   a_clip_rise: assert property ($rose(clip_o) |-> $past(sample_valid_i, 2))
      else $error("clip rose without sample");
   a_clip_fall: assert property ($fell(clip_o) |-> $past(sample_valid_i, 2))
      else $error("clip fell without sample");
   a_clip_dwell: assert property ($rose(clip_o) |-> clip_o [*2])
      else $error("clip dropped too soon");
   a_loss_rise: assert property ($rose(loss_of_signal_o) |-> $past(sample_valid_i, 2))
      else $error("loss rose without sample");
   // Accumulator moves only on samples or after a control write
   a_acc_hold: assert property (
      !$past(sample_valid_i) && !$past(wr_i) && !$past(wr_i, 2) |-> $stable(acc_o))
      else $error("accumulator moved while idle");
   a_acc_clear: assert property (
      wr_i && addr_i == CTRL_ADDR && wdata_i[0] ##1 !wr_i |=> acc_o == ACC_RESET)
      else $error("accumulator not cleared");
   c_clip: cover property ($rose(clip_o));
   c_unclip: cover property ($fell(clip_o));
   c_loss: cover property ($rose(loss_of_signal_o));
endmodule
bind rascd_top rascd_props u_props (.*);
`default_nettype wire

// File: dv/rascd_top_test.sv
// Self-checking bench for the signal-detect and clip-detect block.
// Assumes package, design and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module rascd_top_test import rascd_pkg::*;;
   logic        clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, sample_valid_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000, sample_mag_i = 16'h0000, loop_err_i = 16'h0000, rdata_o;
   logic [31:0] squared_i = 32'h0000_0000, acc_o;
   logic [23:0] integ_time0_o, integ_time1_o;
   logic        loss_of_signal_o, clip_o, irq_o;
   int          num_errors = 0, total_checks = 0, cyc = 0;
   logic [23:0] cfg [8] = '{24'h0b0064, 24'h0c0032, 24'h0d0004, 24'h0e0004,
                            24'h0f0202, 24'h100010, 24'h0a0000, 24'h230002};
   rascd_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_valid_i(sample_valid_i),
      .squared_i(squared_i), .sample_mag_i(sample_mag_i), .loop_err_i(loop_err_i),
      .loss_of_signal_o(loss_of_signal_o), .clip_o(clip_o), .acc_o(acc_o),
      .integ_time0_o(integ_time0_o), .integ_time1_o(integ_time1_o), .irq_o(irq_o));
   // Free-running 100 MHz clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Hang guard, far above the roughly 140 cycles the run needs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail("timeout");
         test_done();
      end
   end
   task automatic fail(string m);
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic chk16(logic [15:0] g, logic [15:0] e);
      total_checks++;
      if (g !== e) fail("read data");
   endtask
   task automatic chk32(logic [31:0] g, logic [31:0] e);
      total_checks++;
      if (g !== e) fail("wide output");
   endtask
   task automatic chk1(logic g, logic e);
      total_checks++;
      if (g !== e) fail("flag");
   endtask
   // Bus tasks hold strobes until the next edge; entered just after an edge
   task automatic bus(logic w, logic r, logic [7:0] a, logic [15:0] d);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= d;
      sample_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask
   task automatic rd_chk(logic [7:0] a, logic [15:0] e);
      bus(1'b0, 1'b1, a, 16'h0000);
      rd_i <= 1'b0;
      #1 chk16(rdata_o, e);
      @(posedge clk_i);
   endtask
   task automatic smp(logic v, logic [31:0] sq, logic [15:0] mag);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      sample_valid_i <= v;
      squared_i <= sq;
      sample_mag_i <= mag;
      @(posedge clk_i);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      wr(CH0_INTEG_LOW_ADDR, 16'h1234);
      wr(CH0_INTEG_HIGH_ADDR, 16'h5a56);
      for (int a = 8; a <= 18; a++) begin
         rd_chk(8'(a), REG_RESET);
         wr(8'(a), {8'(a), 8'hc3});
         rd_chk(8'(a), {8'(a), 8'hc3});
      end
      chk32({8'h00, integ_time1_o}, 32'h00c3_11c3);
      chk32({8'h00, integ_time0_o}, 32'h0056_1234);
      wr(8'h30, 16'hffff);
      rd_chk(8'h30, 16'h0000);
      foreach (cfg[i]) wr(cfg[i][23:16], cfg[i][15:0]);
      // Boundary magnitude is no hit; one hit alone lets the window close
      repeat (2) smp(1'b1, 32'h0, 16'h0064);
      smp(1'b1, 32'h0, 16'h00c8);
      repeat (3) smp(1'b1, 32'h0, 16'h0050);
      repeat (2) smp(1'b0, 32'h0, 16'h0000);
      chk1(clip_o, 1'b0);
      repeat (2) smp(1'b1, 32'h0, 16'h00c8);
      repeat (2) smp(1'b0, 32'h0, 16'h0000);
      chk1(clip_o, 1'b1);
      chk1(irq_o, 1'b1);
      repeat (3) smp(1'b1, 32'h0, 16'h0050);
      smp(1'b0, 32'h0, 16'h0000);
      chk1(clip_o, 1'b1);
      chk32(acc_o, 32'h0000_0030);
      repeat (2) smp(1'b1, 32'h0, 16'h000a);
      repeat (3) smp(1'b0, 32'h0, 16'h0000);
      chk1(clip_o, 1'b0);
      chk32(acc_o, 32'h0000_0050);
      rd_chk(IRQ_STATUS_ADDR, 16'h0006);
      wr(IRQ_MASK_ADDR, 16'h0000);
      smp(1'b0, 32'h0, 16'h0000);
      chk1(irq_o, 1'b0);
      wr(IRQ_STATUS_ADDR, 16'h0007);
      rd_chk(IRQ_STATUS_ADDR, 16'h0000);
      // Clear holds the accumulator at zero even with a sample present
      wr(CTRL_ADDR, 16'h0001);
      loop_err_i <= 16'hfff0;
      smp(1'b1, 32'h0, 16'h0050);
      smp(1'b0, 32'h0, 16'h0000);
      chk32(acc_o, 32'h0000_0000);
      wr(CTRL_ADDR, 16'h0000);
      // Loss level sits on squared bit 8; top bits count as loud
      wr(CH0_LOSS_DETECT_LEVEL, 16'h0100);
      wr(CH0_LOSS_WINDOW_LENGTH, 16'h0003);
      wr(CH0_LOSS_SAMPLE_COUNT, 16'h0002);
      repeat (3) smp(1'b1, 32'h0001_0000, 16'h0000);
      rd_chk(IRQ_STATUS_ADDR, 16'h0000);
      smp(1'b1, 32'h0000_ffff, 16'h0000);
      repeat (2) smp(1'b1, 32'h8000_0000, 16'h0000);
      repeat (2) smp(1'b0, 32'h0, 16'h0000);
      chk1(loss_of_signal_o, 1'b0);
      repeat (2) smp(1'b1, 32'h0000_ffff, 16'h0000);
      repeat (2) smp(1'b0, 32'h0, 16'h0000);
      chk1(loss_of_signal_o, 1'b1);
      rd_chk(STATE_ADDR, 16'h0001);
      smp(1'b1, 32'h0001_0000, 16'h0000);
      repeat (2) smp(1'b0, 32'h0, 16'h0000);
      chk1(loss_of_signal_o, 1'b0);
      rd_chk(IRQ_STATUS_ADDR, 16'h0001);
      rd_chk(ACC_LOW_ADDR, 16'hff70);
      rd_chk(ACC_HIGH_ADDR, 16'hffff);
      test_done();
   end
endmodule
`default_nettype wire
